// >>> rtl/ifrc_flags.v
// Interrupt flag registers and reset control register with a Wishbone slave
//
// Overview of operation
// - Control bit 7 enables two interrupt priority levels; zero means single level.
// - Control bit 5 is unimplemented and always reads zero.
// - Reset-instruction, watchdog, powerdown flags reset to one; power-on, brownout to zero.
// - Parallel port flag sets on external port read or write, held until cleared.
// - Converter-done flag sets when a conversion finishes, held until written zero.
// - Serial receive flag is read-only, high while the receive buffer holds data.
// - Serial transmit flag is read-only, high while the transmit buffer is empty.
// - First capture/compare flag sets on capture or match by mode; unused in PWM.
// - Second capture/compare flag at bit 0 behaves the same way.
// - Second flag register bits 7, 5 and 4 always read zero.
// - Comparator flag at bit 6 sets whenever a comparator input changes.
// - Bus collision flag at bit 3 sets on a collision, held until cleared.
// - Low-voltage flag at bit 2 sets below the trip point, held until cleared.
// - Third timer overflow flag at bit 1 sets on overflow; software clears it.
// - Flags set on their events regardless of any enable bit.
// - Transmit buffer flags 0 to 2 set when that buffer finishes sending.
// - Receive buffer flags 0 and 1 set when that buffer gets a message.
// - Third flag register bit 7 invalid message, bit 6 wake-up, bit 5 error.
`timescale 1ns/1ps
`include "ifrc_defines.vh"

module ifrc_flags (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Parallel port and converter events
  input  wire        parallel_access_i,
  input  wire        conversion_done_i,
  // Serial port status levels
  input  wire        serial_rx_full_i,
  input  wire        serial_tx_empty_i,
  // Synchronous serial port events
  input  wire        sync_serial_done_i,
  input  wire        bus_collision_i,
  // Capture/compare unit one
  input  wire [1:0]  capcomp_one_mode_i,
  input  wire        capcomp_one_capture_i,
  input  wire        capcomp_one_match_i,
  // Capture/compare unit two
  input  wire [1:0]  capcomp_two_mode_i,
  input  wire        capcomp_two_capture_i,
  input  wire        capcomp_two_match_i,
  // Timer events
  input  wire        timer_one_overflow_i,
  input  wire        timer_two_match_i,
  input  wire        timer_three_overflow_i,
  // Analog status
  input  wire [1:0]  comparator_out_i,
  input  wire        low_voltage_i,
  // Controller-area-network events
  input  wire        invalid_message_i,
  input  wire        bus_wakeup_i,
  input  wire        module_error_i,
  input  wire [2:0]  tx_buffer_done_i,
  input  wire [1:0]  rx_buffer_new_i,
  // Control and flag state
  output wire        priority_levels_enable_o,
  output wire        long_write_enable_o,
  output wire [7:0]  reset_control_o,
  output wire [7:0]  peripheral_flags_one_o,
  output wire [7:0]  peripheral_flags_two_o,
  output wire [7:0]  peripheral_flags_three_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // Capture/compare flag set condition for the unit's mode
  function capcomp_set;
    input [1:0] mode;
    input       capture;
    input       match;
    begin
      case (mode)
        `IFRC_CC_MODE_CAPTURE: capcomp_set = capture;
        `IFRC_CC_MODE_COMPARE: capcomp_set = match;
        default:               capcomp_set = 1'b0;
      endcase
    end
  endfunction

  // Register selection from the byte address
  function is_reg;
    input [7:0] adr;
    input [7:0] off;
    begin
      is_reg = (adr[7:2] == off[7:2]);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave

  wire       bus_req;
  wire       wr_fire;
  wire [7:0] wr_byte;
  wire       wr_reset_ctrl;
  wire       wr_flags_one;
  wire       wr_flags_two;
  wire       wr_flags_three;
  reg  [7:0] next_rdata;

  assign bus_req        = wb_cyc_i & wb_stb_i;
  // Writes commit on the edge at which the master sees ack
  assign wr_fire        = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];
  assign wr_byte        = wb_dat_i[7:0];
  assign wr_reset_ctrl  = wr_fire & is_reg(wb_adr_i, `IFRC_OFF_RESET_CTRL);
  assign wr_flags_one   = wr_fire & is_reg(wb_adr_i, `IFRC_OFF_FLAGS_ONE);
  assign wr_flags_two   = wr_fire & is_reg(wb_adr_i, `IFRC_OFF_FLAGS_TWO);
  assign wr_flags_three = wr_fire & is_reg(wb_adr_i, `IFRC_OFF_FLAGS_THREE);

  always @* begin
    if (is_reg(wb_adr_i, `IFRC_OFF_RESET_CTRL)) begin
      next_rdata = reset_control_o;
    end else if (is_reg(wb_adr_i, `IFRC_OFF_FLAGS_ONE)) begin
      next_rdata = peripheral_flags_one_o;
    end else if (is_reg(wb_adr_i, `IFRC_OFF_FLAGS_TWO)) begin
      next_rdata = peripheral_flags_two_o;
    end else if (is_reg(wb_adr_i, `IFRC_OFF_FLAGS_THREE)) begin
      next_rdata = peripheral_flags_three_o;
    end else begin
      // Unmapped addresses answer with zero
      next_rdata = 8'h00;
    end
  end

  // Ack one cycle after the request, dropped in the following cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      if (bus_req & ~wb_ack_o) begin
        wb_dat_o <= {24'h00_0000, next_rdata};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset and priority control

  reg [7:0] reset_ctrl;

  always @(posedge clk_i) begin
    if (rst_i) begin
      reset_ctrl <= `IFRC_RC_RESET;
    end else if (wr_reset_ctrl) begin
      reset_ctrl <= wr_byte & `IFRC_RC_IMPL_MASK;
    end
  end

  assign reset_control_o          = reset_ctrl;
  assign priority_levels_enable_o = reset_ctrl[`IFRC_RC_PRIO_EN];
  assign long_write_enable_o      = reset_ctrl[`IFRC_RC_LONG_WR];

  ////////////////////////////////////////////////////////////////////////////
  // Analog status synchroniser

  reg  [2:0] async_meta;
  reg  [2:0] async_sync;
  wire [1:0] cmp_sync;
  wire       low_volt_sync;

  // Comparator and low-voltage outputs come from analog circuits with no
  // relation to the clock; only the second stage may be read by logic
  always @(posedge clk_i) begin
    async_meta <= {low_voltage_i, comparator_out_i};
    async_sync <= async_meta;
  end

  assign cmp_sync      = async_sync[1:0];
  assign low_volt_sync = async_sync[2];

  ////////////////////////////////////////////////////////////////////////////
  // Event conditioning

  reg  [1:0] cmp_prev;
  reg        cmp_primed;
  reg        rx_full_q;
  reg        tx_empty_q;
  wire       cmp_changed;

  // Change detect on the comparator outputs; primed so reset release is no event
  always @(posedge clk_i) begin
    if (rst_i) begin
      cmp_prev   <= 2'h0;
      cmp_primed <= 1'b0;
      rx_full_q  <= 1'b0;
      tx_empty_q <= 1'b0;
    end else begin
      cmp_prev   <= cmp_sync;
      cmp_primed <= 1'b1;
      rx_full_q  <= serial_rx_full_i;
      tx_empty_q <= serial_tx_empty_i;
    end
  end

  assign cmp_changed = cmp_primed & (|(cmp_prev ^ cmp_sync));

  ////////////////////////////////////////////////////////////////////////////
  // First flag register

  wire [7:0] set_one;
  wire [7:0] sticky_one;

  // Events set flags with no regard to any enable bit
  assign set_one[`IFRC_F1_PARALLEL]     = parallel_access_i;
  assign set_one[`IFRC_F1_CONVERTER]    = conversion_done_i;
  assign set_one[`IFRC_F1_SER_RX]       = 1'b0;
  assign set_one[`IFRC_F1_SER_TX]       = 1'b0;
  assign set_one[`IFRC_F1_SYNC_SERIAL]  = sync_serial_done_i;
  assign set_one[`IFRC_F1_CAPCOMP_ONE]  = capcomp_set(capcomp_one_mode_i,
                                                      capcomp_one_capture_i,
                                                      capcomp_one_match_i);
  assign set_one[`IFRC_F1_TIMER_TWO]    = timer_two_match_i;
  assign set_one[`IFRC_F1_TIMER_ONE]    = timer_one_overflow_i;

  ifrc_flag_bank #(
    .WIDTH     (8),
    .IMPL_MASK (`IFRC_F1_STICKY_MASK),
    .RESET_VAL (`IFRC_FLAGS_RESET)
  ) u_flags_one (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .set_i   (set_one),
    .wr_i    (wr_flags_one),
    .wdata_i (wr_byte),
    .flags_o (sticky_one)
  );

  // Serial status bits ignore writes and follow the serial port
  assign peripheral_flags_one_o = {sticky_one[7:6], rx_full_q, tx_empty_q,
                                   sticky_one[3:0]};

  ////////////////////////////////////////////////////////////////////////////
  // Second flag register

  wire [7:0] set_two;

  assign set_two[7]                     = 1'b0;
  assign set_two[`IFRC_F2_COMPARATOR]   = cmp_changed;
  assign set_two[5:4]                   = 2'h0;
  assign set_two[`IFRC_F2_BUS_COLL]     = bus_collision_i;
  assign set_two[`IFRC_F2_LOW_VOLT]     = low_volt_sync;
  assign set_two[`IFRC_F2_TIMER_THREE]  = timer_three_overflow_i;
  assign set_two[`IFRC_F2_CAPCOMP_TWO]  = capcomp_set(capcomp_two_mode_i,
                                                      capcomp_two_capture_i,
                                                      capcomp_two_match_i);

  // Unimplemented positions are left out of the bank
  ifrc_flag_bank #(
    .WIDTH     (8),
    .IMPL_MASK (`IFRC_F2_IMPL_MASK),
    .RESET_VAL (`IFRC_FLAGS_RESET)
  ) u_flags_two (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .set_i   (set_two),
    .wr_i    (wr_flags_two),
    .wdata_i (wr_byte),
    .flags_o (peripheral_flags_two_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Third flag register

  wire [7:0] set_three;

  assign set_three[`IFRC_F3_INVALID_MSG] = invalid_message_i;
  assign set_three[`IFRC_F3_WAKEUP]      = bus_wakeup_i;
  assign set_three[`IFRC_F3_MOD_ERROR]   = module_error_i;
  assign set_three[`IFRC_F3_TX_BUF_LSB+2:`IFRC_F3_TX_BUF_LSB] = tx_buffer_done_i;
  assign set_three[`IFRC_F3_RX_BUF_LSB+1:`IFRC_F3_RX_BUF_LSB] = rx_buffer_new_i;

  ifrc_flag_bank #(
    .WIDTH     (8),
    .IMPL_MASK (`IFRC_F3_IMPL_MASK),
    .RESET_VAL (`IFRC_FLAGS_RESET)
  ) u_flags_three (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .set_i   (set_three),
    .wr_i    (wr_flags_three),
    .wdata_i (wr_byte),
    .flags_o (peripheral_flags_three_o)
  );

endmodule // ifrc_flags

// >>> rtl/ifrc_defines.vh
// Constants for the interrupt flag and reset control block
`ifndef IFRC_DEFINES_VH
`define IFRC_DEFINES_VH

// Register byte offsets on the bus
`define IFRC_OFF_RESET_CTRL     8'h00
`define IFRC_OFF_FLAGS_ONE      8'h04
`define IFRC_OFF_FLAGS_TWO      8'h08
`define IFRC_OFF_FLAGS_THREE    8'h0C

// Reset and priority control fields
`define IFRC_RC_PRIO_EN         7
`define IFRC_RC_LONG_WR         6
`define IFRC_RC_UNUSED          5
`define IFRC_RC_RESET_INSTR     4
`define IFRC_RC_WDOG            3
`define IFRC_RC_PWRDN           2
`define IFRC_RC_PWRON           1
`define IFRC_RC_BROWNOUT        0
`define IFRC_RC_RESET           8'h1C
`define IFRC_RC_IMPL_MASK       8'hDF

// First flag register fields
`define IFRC_F1_PARALLEL        7
`define IFRC_F1_CONVERTER       6
`define IFRC_F1_SER_RX          5
`define IFRC_F1_SER_TX          4
`define IFRC_F1_SYNC_SERIAL     3
`define IFRC_F1_CAPCOMP_ONE     2
`define IFRC_F1_TIMER_TWO       1
`define IFRC_F1_TIMER_ONE       0
`define IFRC_F1_STICKY_MASK     8'hCF

// Second flag register fields
`define IFRC_F2_COMPARATOR      6
`define IFRC_F2_BUS_COLL        3
`define IFRC_F2_LOW_VOLT        2
`define IFRC_F2_TIMER_THREE     1
`define IFRC_F2_CAPCOMP_TWO     0
`define IFRC_F2_IMPL_MASK       8'h4F

// Third flag register fields
`define IFRC_F3_INVALID_MSG     7
`define IFRC_F3_WAKEUP          6
`define IFRC_F3_MOD_ERROR       5
`define IFRC_F3_TX_BUF_LSB      2
`define IFRC_F3_RX_BUF_LSB      0
`define IFRC_F3_IMPL_MASK       8'hFF

// Flag registers reset to zero
`define IFRC_FLAGS_RESET        8'h00

// Capture/compare mode codes
`define IFRC_CC_MODE_OFF        2'h0
`define IFRC_CC_MODE_CAPTURE    2'h1
`define IFRC_CC_MODE_COMPARE    2'h2
`define IFRC_CC_MODE_PWM        2'h3

`endif

// >>> rtl/ifrc_flag_bank.v
// Bank of sticky flag bits: hardware sets, software writes
`timescale 1ns/1ps

module ifrc_flag_bank #(
  parameter       WIDTH     = 8,
  parameter [7:0] IMPL_MASK = 8'hFF,
  parameter [7:0] RESET_VAL = 8'h00
) (
  // Clock and reset
  input  wire             clk_i,
  input  wire             rst_i,
  // Hardware set and software write
  input  wire [WIDTH-1:0] set_i,
  input  wire             wr_i,
  input  wire [WIDTH-1:0] wdata_i,
  // Flag state
  output wire [WIDTH-1:0] flags_o
);

  genvar g;

  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      if (IMPL_MASK[g]) begin : g_impl
        reg flag;
        // A set in the same cycle as a clearing write wins
        always @(posedge clk_i) begin
          if (rst_i) begin
            flag <= RESET_VAL[g];
          end else if (set_i[g]) begin
            flag <= 1'b1;
          end else if (wr_i) begin
            flag <= wdata_i[g];
          end
        end
        assign flags_o[g] = flag;
      end else begin : g_unimpl
        // Unimplemented positions read as zero
        assign flags_o[g] = 1'b0;
      end
    end
  endgenerate

endmodule // ifrc_flag_bank

// >>> verification/ifrc_flags_checker.sv
// Assertions on the ports of the flag and control block
`timescale 1ns/1ps
module ifrc_flags_checker (
  // Clock, reset and bus
  input logic       clk_i,
  input logic       rst_i,
  input logic       wb_cyc_i,
  input logic       wb_stb_i,
  input logic       wb_we_i,
  input logic [7:0] wb_adr_i,
  input logic [3:0] wb_sel_i,
  input logic       wb_ack_o,
  // Events and levels
  input logic       parallel_access_i,
  input logic       serial_rx_full_i,
  input logic       serial_tx_empty_i,
  input logic [1:0] capcomp_one_mode_i,
  input logic       capcomp_one_capture_i,
  input logic       low_voltage_i,
  input logic [2:0] tx_buffer_done_i,
  // Register state
  input logic       priority_levels_enable_o,
  input logic [7:0] reset_control_o,
  input logic [7:0] peripheral_flags_one_o,
  input logic [7:0] peripheral_flags_two_o,
  input logic [7:0] peripheral_flags_three_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_answer; wb_ack_o ##1 !wb_ack_o; endsequence
  logic f1_write;
  assign f1_write = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] &&
                    wb_adr_i[7:2] == 6'h01;
  a_ack_one_pulse: assert property (s_req |=> s_answer)
    else $error("bus answer is not a single ack cycle");
  a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  a_prio_follows_bit: assert property (priority_levels_enable_o == reset_control_o[7])
    else $error("priority enable differs from control bit");
  a_ctrl_gap_zero: assert property (reset_control_o[5] == 1'b0)
    else $error("unused control bit set");
  a_f2_gap_zero: assert property ((peripheral_flags_two_o & 8'hB0) == 8'h00)
    else $error("unused flag bits set");
  a_parallel_sets: assert property (parallel_access_i |=> peripheral_flags_one_o[7])
    else $error("parallel port flag not set");
  a_parallel_held: assert property (peripheral_flags_one_o[7] && !f1_write |=>
    peripheral_flags_one_o[7])
    else $error("parallel port flag lost");
  a_rx_mirror: assert property (1'b1 |=>
    peripheral_flags_one_o[5] == $past(serial_rx_full_i))
    else $error("receive flag does not follow buffer");
  a_tx_mirror: assert property (1'b1 |=>
    peripheral_flags_one_o[4] == $past(serial_tx_empty_i))
    else $error("transmit flag does not follow buffer");
  a_capture_sets: assert property (capcomp_one_mode_i == 2'h1 &&
    capcomp_one_capture_i |=> peripheral_flags_one_o[2])
    else $error("capture flag not set");
  a_low_volt_sets: assert property (low_voltage_i |-> ##3 peripheral_flags_two_o[2])
    else $error("low voltage flag not set");
  a_tx_buf_sets: assert property (tx_buffer_done_i != 3'h0 |=>
    (peripheral_flags_three_o[4:2] & $past(tx_buffer_done_i)) == $past(tx_buffer_done_i))
    else $error("transmit buffer flag not set");
endmodule // ifrc_flags_checker
bind ifrc_flags ifrc_flags_checker u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_ack_o, .parallel_access_i, .serial_rx_full_i, .serial_tx_empty_i,
  .capcomp_one_mode_i, .capcomp_one_capture_i, .low_voltage_i, .tx_buffer_done_i,
  .priority_levels_enable_o, .reset_control_o, .peripheral_flags_one_o,
  .peripheral_flags_two_o, .peripheral_flags_three_o);

// >>> verification/ifrc_periph_model.sv
// Peripheral event source feeding the flag block
`timescale 1ns/1ps
module ifrc_periph_model (
  // Clock
  input  wire        clk_i,
  // Event requests
  input  wire [19:0] go_i,
  // Events towards the flag block
  output reg  [19:0] ev_o
);
  initial ev_o = 20'h0_0000;
  // Each requested event appears one cycle after the request
  always @(posedge clk_i) begin
    ev_o <= go_i;
  end
endmodule // ifrc_periph_model

// >>> verification/ifrc_flags_tb.sv
// Register bus testbench for the flag and control block
`timescale 1ns/1ps
module ifrc_flags_tb;
  logic        clk;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000;
  logic [31:0] q_o;
  logic        ack;
  logic        prio;
  logic        lwe;
  logic        rx = 1'b0;
  logic        tx = 1'b0;
  logic [1:0]  m1 = 2'h0;
  logic [1:0]  m2 = 2'h0;
  logic [1:0]  cmp = 2'h0;
  logic [19:0] go = 20'h0_0000;
  logic [19:0] ev;
  logic [7:0]  a;
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          evn [16] = '{0, 1, 2, 4, 5, 3, 6, 19, 7, 8, 9, 10, 11, 12, 13, 14};
  int          bit_of [16] = '{7, 6, 3, 0, 1, 3, 1, 2, 7, 6, 5, 2, 3, 4, 0, 1};

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ifrc_periph_model u_model (.clk_i(clk), .go_i(go), .ev_o(ev));

  ifrc_flags u_dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(q_o), .wb_ack_o(ack),
    .parallel_access_i(ev[0]), .conversion_done_i(ev[1]), .serial_rx_full_i(rx),
    .serial_tx_empty_i(tx), .sync_serial_done_i(ev[2]), .bus_collision_i(ev[3]),
    .capcomp_one_mode_i(m1), .capcomp_one_capture_i(ev[15]), .capcomp_one_match_i(ev[16]),
    .capcomp_two_mode_i(m2), .capcomp_two_capture_i(ev[17]), .capcomp_two_match_i(ev[18]),
    .timer_one_overflow_i(ev[4]), .timer_two_match_i(ev[5]), .timer_three_overflow_i(ev[6]),
    .comparator_out_i(cmp), .low_voltage_i(ev[19]), .invalid_message_i(ev[7]),
    .bus_wakeup_i(ev[8]), .module_error_i(ev[9]), .tx_buffer_done_i(ev[12:10]),
    .rx_buffer_new_i(ev[14:13]), .priority_levels_enable_o(prio), .long_write_enable_o(lwe),
    .reset_control_o(), .peripheral_flags_one_o(), .peripheral_flags_two_o(),
    .peripheral_flags_three_o());

  task automatic end_sim;
    $display("Mismatches %0d of %0d comparisons", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // Single classic cycle; request held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] ad, input logic [7:0] d,
                     output logic [31:0] q);
    int i;
    @(posedge clk);
    {cyc, stb, we, adr, dat} <= {2'b11, w, ad, 24'h00_0000, d};
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1 && i < 50);
    q = q_o;
    {cyc, stb} <= 2'b00;
    if (i >= 50) begin
      n_mismatch++;
      end_sim();
    end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, ad, d, q);
  endtask

  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, ad, 8'h00, q);
    check(q, {24'h00_0000, e});
  endtask

  task automatic pulse(input int b);
    @(posedge clk);
    go <= 20'h0_0001 << b;
    @(posedge clk);
    go <= 20'h0_0000;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(8'h00, 8'h1C);
    wr(8'h00, 8'hFF);
    rd(8'h00, 8'hDF);
    check({31'h0000_0000, prio}, 32'h0000_0001);
    check({31'h0000_0000, lwe}, 32'h0000_0001);
    wr(8'h00, 8'h00);
    // The write lands at the ack edge; look one edge later
    @(posedge clk);
    check({31'h0000_0000, prio}, 32'h0000_0000);
    check({31'h0000_0000, lwe}, 32'h0000_0000);
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'h00);
    wr(8'h08, 8'hFF);
    rd(8'h08, 8'h4F);
    wr(8'h08, 8'h00);
    for (int k = 0; k < 16; k++) begin
      a = (k < 5) ? 8'h04 : (k < 8) ? 8'h08 : 8'h0C;
      pulse(evn[k]);
      // Two more edges for the analog status synchroniser
      repeat (2) @(posedge clk);
      if (k < 5) begin
        rd(a, 8'h01 << bit_of[k]);
      end else if (k < 8) begin
        rd(a, 8'h01 << bit_of[k]);
      end else begin
        rd(a, 8'h01 << bit_of[k]);
      end
      wr(a, 8'h00);
      rd(a, 8'h00);
    end
    for (int m = 0; m < 4; m++) begin
      {m1, m2} <= {m[1:0], m[1:0]};
      pulse(15);
      rd(8'h04, (m == 1) ? 8'h04 : 8'h00);
      pulse(17);
      rd(8'h08, (m == 1) ? 8'h01 : 8'h00);
      pulse(16);
      rd(8'h04, (m == 1 || m == 2) ? 8'h04 : 8'h00);
      pulse(18);
      rd(8'h08, (m == 1 || m == 2) ? 8'h01 : 8'h00);
      wr(8'h04, 8'h00);
      wr(8'h08, 8'h00);
    end
    rx <= 1'b1;
    rd(8'h04, 8'h20);
    wr(8'h04, 8'h00);
    rd(8'h04, 8'h20);
    {rx, tx} <= 2'b01;
    rd(8'h04, 8'h10);
    cmp <= 2'h1;
    repeat (2) @(posedge clk);
    rd(8'h08, 8'h40);
    wr(8'h08, 8'h00);
    rd(8'h08, 8'h00);
    end_sim();
  end
endmodule // ifrc_flags_tb
